//--- rtl/rtc_hour_counter_read_guard.sv
/*
 hour counter of the real-time clock with its update-in-progress flag,
 wishbone register slave and masked interrupt.
 assumes minute_carry and update_start come from clock logic on sys_clk
 as one-cycle pulses; the bus master is a classic wishbone master.
*/
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
//
// Behaviour
// (RULE1) hour is bcd and steps only on the minute carry pulse
// (RULE2) range 00..11 in twelve-hour mode, 00..23 in 24-hour mode
// (RULE3) bit 7 reads 1 while the time update runs, else 0
// (RULE4) bit 6 always reads 0
// (RULE5) tens of hours in bits 5:4, writable, counts 0 to 2
// (RULE6) ones in bits 3:0, writable, 0 to 9, carry bumps tens
// (RULE7) update flag clears about 62.5 ms after it rises
// (RULE8) software reads time after seeing the update flag fall
// (RULE9) or after the clock interrupt with update flag seen 0
// (RULE10) or reads twice and keeps matching values
// (RULE11) at the top value a minute carry wraps the hour to 00
`timescale 1ns/10ps
`include "rtc_hour_params.svh"

module rtc_hour_counter_read_guard #(
   parameter int UPD_CYCLES = `UPD_CYCLES
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic minute_carry,
   input wire logic update_start,
   output logic update_in_progress_flag,
   output logic twelve_hour_sel,
   output logic clock_interrupt_request_flag
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // top of the range for the chosen format
   function automatic rtc_hour_pkg::hour_s hour_top(
      input logic twelve
   );
      rtc_hour_pkg::hour_s t;
      if (twelve)
      begin
         t.tens = 2'h1;
         t.ones = 4'h1;
      end
      else
      begin
         t.tens = 2'h2;
         t.ones = 4'h3;
      end
      return t;
   endfunction

   // one bcd step; an illegal ones digit carries like a nine
   function automatic rtc_hour_pkg::hour_s hour_step(
      input rtc_hour_pkg::hour_s h,
      input logic twelve
   );
      rtc_hour_pkg::hour_s n;
      n = h;
      if (h == hour_top(twelve))
      begin
         n.tens = 2'h0; // RULE11
         n.ones = 4'h0; // RULE11
      end
      else if (h.ones >= 4'h9)
      begin
         n.ones = 4'h0; // RULE6
         n.tens = h.tens + 2'h1; // RULE6
      end
      else
      begin
         n.ones = h.ones + 4'h1; // RULE6
      end
      return n;
   endfunction

   // true when the hour lies beyond the format's top
   function automatic logic hour_over(
      input rtc_hour_pkg::hour_s h,
      input logic twelve
   );
      rtc_hour_pkg::hour_s t;
      t = hour_top(twelve);
      return ({h.tens, h.ones} > {t.tens, t.ones});
   endfunction

   // byte-lane merge of the low byte
   function automatic logic [7:0] lane0(
      input logic [7:0] old_v,
      input logic [31:0] wr,
      input logic [3:0] sel
   );
      return sel[0] ? wr[7:0] : old_v;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   rtc_hour_pkg::state_s st_r;
   rtc_hour_pkg::state_s st_nxt;

   logic req;
   logic rd_go;
   logic wr_go;
   logic ev_done;
   logic ev_wrap;
   logic [7:0] hour_byte;
   logic [7:0] wr_byte;
   logic [7:0] ctrl_byte;
   logic [23:0] upd_last;

   assign req = wb_cyc_i & wb_stb_i;
   // answer one cycle after the strobe, ack low in between
   assign rd_go = req & ~st_r.ack & ~wb_we_i;
   assign wr_go = req & ~st_r.ack & wb_we_i;
   // a parameter is 32 bits; the counter is 24
   assign upd_last = 24'(UPD_CYCLES - 1);

   // hour register image seen by software
   always_comb
   begin
      hour_byte = 8'h00;
      hour_byte[`POS_BUSY] = (st_r.upd == rtc_hour_pkg::UPD_RUN); // RULE3
      hour_byte[`POS_RSVD] = 1'b0; // RULE4
      hour_byte[5:4] = st_r.hour.tens; // RULE5
      hour_byte[3:0] = st_r.hour.ones; // RULE6
   end

   always_comb
   begin
      ctrl_byte = 8'h00;
      ctrl_byte[`POS_TWELVE] = st_r.twelve;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      ev_done = 1'b0;
      ev_wrap = 1'b0;
      wr_byte = 8'h00;

      // update sequencer
      case (st_r.upd)
         rtc_hour_pkg::UPD_IDLE:
         begin
            if (update_start)
            begin
               st_nxt.upd = rtc_hour_pkg::UPD_RUN; // RULE3
               st_nxt.upd_cnt = 24'h000000;
            end
         end
         rtc_hour_pkg::UPD_RUN:
         begin
            // restart requests while running are ignored
            if (st_r.upd_cnt >= upd_last)
            begin
               st_nxt.upd = rtc_hour_pkg::UPD_IDLE; // RULE7
               st_nxt.upd_cnt = 24'h000000;
               ev_done = 1'b1;
            end
            else
            begin
               st_nxt.upd_cnt = st_r.upd_cnt + 24'h000001; // RULE7
            end
         end
         default:
         begin
            st_nxt.upd = rtc_hour_pkg::UPD_IDLE;
            st_nxt.upd_cnt = 24'h000000;
         end
      endcase

      // hour counting; a software write in the same cycle wins
      if (minute_carry)
      begin
         st_nxt.hour = hour_step(st_r.hour, st_r.twelve); // RULE1
         ev_wrap = (st_r.hour == hour_top(st_r.twelve)); // RULE11
      end

      // a count left beyond the range after a format change
      // is pulled back to 00 at the next carry
      if (minute_carry && hour_over(st_r.hour, st_r.twelve))
      begin
         st_nxt.hour.tens = 2'h0; // RULE2
         st_nxt.hour.ones = 4'h0; // RULE2
         ev_wrap = 1'b1;
      end

      // bus slave
      st_nxt.ack = req & ~st_r.ack;
      if (rd_go)
      begin
         case (wb_adr_i)
            `OFS_HOUR_COUNT:
               st_nxt.dat = {24'h000000, hour_byte};
            `OFS_CTRL:
               st_nxt.dat = {24'h000000, ctrl_byte};
            `OFS_IRQ_STATUS:
               st_nxt.dat = {30'h0, st_r.irq_status};
            `OFS_IRQ_MASK:
               st_nxt.dat = {30'h0, st_r.irq_mask};
            default:
               st_nxt.dat = 32'h00000000;
         endcase
      end
      else
      begin
         st_nxt.dat = 32'h00000000;
      end

      if (wr_go)
      begin
         case (wb_adr_i)
            `OFS_HOUR_COUNT:
            begin
               wr_byte = lane0(hour_byte, wb_dat_i, wb_sel_i);
               // busy and reserved bits are not writable
               st_nxt.hour.tens = wr_byte[5:4]; // RULE5
               st_nxt.hour.ones = wr_byte[3:0]; // RULE6
            end
            `OFS_CTRL:
            begin
               wr_byte = lane0(ctrl_byte, wb_dat_i, wb_sel_i);
               st_nxt.twelve = wr_byte[`POS_TWELVE]; // RULE2
            end
            `OFS_IRQ_MASK:
            begin
               wr_byte = lane0({6'h00, st_r.irq_mask}, wb_dat_i,
                  wb_sel_i);
               st_nxt.irq_mask = wr_byte[1:0];
            end
            default:
            begin
               wr_byte = 8'h00;
            end
         endcase
      end

      // sticky events; read clears, a new event wins over it
      if (rd_go && (wb_adr_i == `OFS_IRQ_STATUS))
      begin
         st_nxt.irq_status = 2'h0;
      end
      if (ev_done)
      begin
         st_nxt.irq_status[`POS_EV_DONE] = 1'b1; // RULE9
      end
      if (ev_wrap)
      begin
         st_nxt.irq_status[`POS_EV_WRAP] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r.hour.tens <= `RST_TENS;
         st_r.hour.ones <= `RST_ONES;
         st_r.twelve <= `RST_TWELVE;
         st_r.upd <= rtc_hour_pkg::UPD_IDLE;
         st_r.upd_cnt <= 24'h000000;
         st_r.irq_status <= `RST_IRQ;
         st_r.irq_mask <= `RST_IRQ;
         st_r.ack <= 1'b0;
         st_r.dat <= 32'h00000000;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = st_r.dat;
   assign update_in_progress_flag =
      (st_r.upd == rtc_hour_pkg::UPD_RUN); // RULE3
   assign twelve_hour_sel = st_r.twelve;
   // level: high while any unmasked sticky bit stands
   assign clock_interrupt_request_flag =
      |(st_r.irq_status & st_r.irq_mask); // RULE9

endmodule // rtc_hour_counter_read_guard

//--- rtl/rtc_hour_params.svh
/*
 constants of the hour counter block: offsets, fields, resets, timing.
 assumes a 32-bit classic wishbone bus and a 200 mhz sys_clk.
*/
`ifndef RTC_HOUR_PARAMS_SVH
`define RTC_HOUR_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_HOUR_COUNT 4'h0
`define OFS_CTRL 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hc

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define POS_BUSY 7
`define POS_RSVD 6
`define POS_TWELVE 0
`define POS_EV_DONE 0
`define POS_EV_WRAP 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_TENS 2'h0
`define RST_ONES 4'h0
`define RST_TWELVE 1'h0
`define RST_IRQ 2'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// kept in ns so that every term fits a 32-bit integer
`define CLK_PERIOD_NS 5
`define UPD_TIME_NS 62500000
`define UPD_CYCLES (`UPD_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/rtc_hour_pkg.sv
/*
 types shared by the hour counter block.
 assumes rtc_hour_params.svh is compiled alongside.
*/
package rtc_hour_pkg;

   // ------------------------------------------------------------
   // hour value as two bcd digits
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] tens;
      logic [3:0] ones;
   } hour_s;

   // ------------------------------------------------------------
   // update sequencer
   // ------------------------------------------------------------
   typedef enum logic {
      UPD_IDLE,
      UPD_RUN
   } upd_e;

   // ------------------------------------------------------------
   // whole state of the block
   // ------------------------------------------------------------
   typedef struct packed {
      hour_s hour;
      logic twelve;
      upd_e upd;
      logic [23:0] upd_cnt;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic ack;
      logic [31:0] dat;
   } state_s;

endpackage

//--- testbench/rtc_hour_asserts.sv
/*
 checker for the hour counter: bus timing, busy flag, format bit.
 sees only the top ports; bound below.
*/
`timescale 1ns/10ps
module rtc_hour_asserts #(
   parameter int UPD_CYCLES = 8
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic minute_carry,
   input wire logic update_start,
   input wire logic update_in_progress_flag,
   input wire logic twelve_hour_sel,
   input wire logic clock_interrupt_request_flag
);
   // ------------------------------------------------------------
   // busy run length
   // ------------------------------------------------------------
   int busy_len;
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         busy_len <= 0;
      else
         busy_len <= update_in_progress_flag ? busy_len + 1 : 0;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence hour_rd_s;
      take_s ##0 (!wb_we_i && wb_adr_i == 4'h0);
   endsequence

   a_ack_follows: assert property (take_s |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_caused: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_busy_bit: assert property (
      hour_rd_s |=> wb_dat_o[7] == $past(update_in_progress_flag))
      else $error("busy bit wrong in hour read");
   a_rsvd_zero: assert property (
      wb_ack_o |-> !wb_dat_o[6] && wb_dat_o[31:8] == 24'h0)
      else $error("reserved bits not zero");
   a_busy_start: assert property (
      update_start && !update_in_progress_flag |=> update_in_progress_flag)
      else $error("busy did not rise");
   a_busy_len: assert property (
      $fell(update_in_progress_flag) |-> busy_len == UPD_CYCLES)
      else $error("busy length wrong");
   a_fmt_stable: assert property (
      !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(twelve_hour_sel))
      else $error("format bit changed without write");
endmodule // rtc_hour_asserts

bind rtc_hour_counter_read_guard rtc_hour_asserts #(
   .UPD_CYCLES(UPD_CYCLES)
) i_rtc_hour_asserts (
   .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .minute_carry(minute_carry),
   .update_start(update_start),
   .update_in_progress_flag(update_in_progress_flag),
   .twelve_hour_sel(twelve_hour_sel),
   .clock_interrupt_request_flag(clock_interrupt_request_flag)
);

//--- testbench/tb.sv
/*
 self-checking bench: integer hour model against register reads.
 assumes a short update window, classic wishbone slave.
*/
`timescale 1ns/10ps
module tb;
   localparam int UPD = 8;
   logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, minute_carry;
   logic update_start, wb_ack_o, busy, fmt, irq, f;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q, d;
   int fail_count, samples_checked, seed, h, n, wrap;

   rtc_hour_counter_read_guard #(.UPD_CYCLES(UPD))
   i_rtc_hour_counter_read_guard (
      .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .minute_carry(minute_carry),
      .update_start(update_start), .update_in_progress_flag(busy),
      .twelve_hour_sel(fmt), .clock_interrupt_request_flag(irq));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until ack is seen at a rising edge, released there
   task automatic bus(input logic we, input logic [3:0] a,
                      input logic [31:0] dd);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= dd;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   function automatic logic [31:0] bcd(input int v);
      return 32'((v / 10) * 16 + v % 10);
   endfunction
   task automatic pulse(input logic c);
      @(posedge sys_clk);
      if (c) minute_carry <= 1'b1; else update_start <= 1'b1;
      @(posedge sys_clk);
      minute_carry <= 1'b0;
      update_start <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #100000;
      fail_count++;
      give_verdict;
   end
   initial
   begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, minute_carry} = 5'h0;
      {update_start, wb_adr_i, wb_dat_i} = 37'h0;
      wb_sel_i = 4'hf;
      seed = 64316;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset values, then an unmapped offset that reads 0
      for (int i = 0; i < 5; i++)
      begin
         bus(0, (i < 4) ? 4'(i * 4) : 4'he, 0);
         chk(q, 32'h0);
      end
      for (int m = 0; m < 2; m++)
      begin
         d = $random(seed);
         f = m[0];
         d[0] = f;
         bus(1, 4'h4, d);
         chk({31'h0, fmt}, {31'h0, f});
         h = {$random(seed)} % (f ? 12 : 24);
         bus(1, 4'h0, bcd(h) | 32'hc0);
         bus(1, 4'h2, $random(seed));
         bus(0, 4'h0, 0);
         chk(q, bcd(h));
         wrap = 0;
         repeat (26)
         begin
            pulse(1);
            if (h >= (f ? 11 : 23)) begin h = 0; wrap = 1; end else h++;
            bus(0, 4'h0, 0);
            chk(q, bcd(h));
         end
         bus(0, 4'h8, 0);
         chk(q, 32'(wrap * 2));
      end
      // count left above the twelve-hour top falls to 00 on a carry
      bus(1, 4'h0, 32'h15);
      pulse(1);
      h = 0;
      bus(0, 4'h0, 0);
      chk(q, 32'h0);
      bus(0, 4'h8, 0);
      chk(q, 32'h2);
      bus(1, 4'hc, 32'h1);
      pulse(0);
      bus(0, 4'h0, 0);
      chk(q, bcd(h) | 32'h80);
      n = 0;
      while (busy === 1'b1 && n++ < 50) @(negedge sys_clk);
      chk({31'h0, irq}, 32'h1);
      bus(0, 4'h8, 0);
      chk(q, 32'h1);
      chk({31'h0, irq}, 32'h0);
      // second start inside the window must not stretch it
      pulse(0);
      pulse(0);
      n = 2;
      do @(negedge sys_clk); while (busy === 1'b1 && n++ < 50);
      chk(32'(n), 32'(UPD));
      bus(1, 4'hc, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(0, 4'h0, 0);
      d = q;
      bus(0, 4'h0, 0);
      chk(q, d);
      // low byte lane disabled: write must not land
      wb_sel_i <= 4'he;
      bus(1, 4'h0, 32'h00000009);
      wb_sel_i <= 4'hf;
      bus(0, 4'h0, 0);
      chk(q, bcd(h));
      bus(1, 4'h0, 32'h00000007);
      // second reset in mid-run: everything back to its reset value
      rst_n <= 1'b0;
      @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(0, 4'h0, 0);
      chk(q, 32'h0);
      chk({29'h0, busy, fmt, irq}, 32'h0);
      give_verdict;
   end
endmodule // tb
